//--- hw/ddc_back_end.sv
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ddc_defs.svh"
// Contract
// - final decimator is 55-tap symmetric half-band
// - final filter can never be bypassed
// - final taps mirror centre 524288
// - third filter 19 taps, centre 131072
// - per-channel gain, 0 dB or 6 dB
// - real conversion stops final downsampling
// - real conversion mixes up by fs/4
// - quadrature product dropped, in-phase kept
// - real conversion enabled per channel
// - third filter bypassed in final-only ratio
// - two-bit ratio field in control bits
module ddc_back_end import ddc_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // samples from the mixer and earlier filters
  input wire logic inValid,
  input wire logic [W-1:0] inI,
  input wire logic [W-1:0] inQ,
  // samples toward the output framer
  output logic outValid,
  output logic [W-1:0] outI,
  output logic [W-1:0] outQ
);
  // the filter accumulators are sized for this range only
  if (W < 8 || W > 32) begin : g_bad_width
    $error("ddc_back_end: sample width not supported");
  end
  // clip limits of the signed output word
  localparam logic signed [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ratio_type ratio;     // filter decimation ratio
    logic c2r;            // complex to real conversion on
    logic gain;           // 6 dB gain on
    logic [31:0] rdata;   // read data, loaded in setup
    logic slvErr;         // unmapped address seen in setup
    logic [31:0] count;   // samples handed to the framer
    logic [1:0] mixPhase; // quarter-rate mixer position
    logic mixValid;
    logic [W-1:0] mixI;
    logic [W-1:0] mixQ;
  } top_state_type;
  top_state_type state;
  top_state_type next_state;

  // ****************************************
  // stage links
  // ****************************************
  sample_if #(.W(W)) inBus ();
  sample_if #(.W(W)) thirdBus ();
  sample_if #(.W(W)) finalBus ();
  sample_if #(.W(W)) mixBus ();
  sample_if #(.W(W)) gainBus ();

  // upstream is on this clock, so no synchroniser
  assign inBus.valid = inValid;
  assign inBus.i = inI;
  assign inBus.q = inQ;

  // negation that clips the most negative code
  function automatic logic [W-1:0] negate(input logic [W-1:0] x);
    if (signed'(x) == MINV) begin
      return MAXV;
    end
    return W'(-signed'(x));
  endfunction : negate

  // decode behind the error answer and its check; read data use their own case
  function automatic logic isMapped(input logic [11:0] addr);
    return addr == `CTRL_OFFSET || addr == `STATUS_OFFSET || addr == `COUNT_OFFSET;
  endfunction : isMapped

  // control word as it reads back
  function automatic logic [31:0] ctrlWord(input top_state_type s);
    logic [31:0] word;
    word = 32'h0000_0000;
    word[`RATIO_LSB +: 2] = s.ratio;
    word[`C2R_BIT] = s.c2r;
    word[`GAIN_BIT] = s.gain;
    return word;
  endfunction : ctrlWord

  logic thirdBypass; // third filter out of the chain
  logic finalDecim;  // final filter halves the rate
  // third filter only in the final-only ratio is skipped
  assign thirdBypass = state.ratio == RATIO_FINAL_ONLY;
  // real conversion keeps the full rate
  assign finalDecim = ~state.c2r;

  // ****************************************
  // filter chain
  // ****************************************
  // every stage is one register deep, so an input that yields an output
  // reaches the framer four edges later: third, final, mixer, gain;
  // a bypassed stage still costs its register, so the latency never
  // depends on the ratio and the framer sees a fixed delay
  // third filter with its own table
  halfband_fir #(
    .W(W),
    .TAPS(`THIRD_TAPS),
    .NSIDE(5),
    .CENTRE(`THIRD_CENTRE),
    .SHIFT(`THIRD_SHIFT),
    .COEF(THIRD_COEF)
  ) thirdFilter (
    .clock(clock),
    .rstn(rstn),
    .decimate(1'b1),
    .bypass(thirdBypass),
    .src(inBus),
    .dst(thirdBus)
  );

  halfband_fir #(
    .W(W),
    .TAPS(`FINAL_TAPS),
    .NSIDE(14),
    .CENTRE(`FINAL_CENTRE),
    .SHIFT(`FINAL_SHIFT),
    .COEF(FINAL_COEF)
  ) finalFilter (
    .clock(clock),
    .rstn(rstn),
    .decimate(finalDecim),
    .bypass(1'b0),
    .src(thirdBus),
    .dst(finalBus)
  );

  // gain is the last stage, so framer data come from its flops
  gain_stage #(
    .W(W)
  ) gainStage (
    .clock(clock),
    .rstn(rstn),
    .gain6db(state.gain),
    .src(mixBus),
    .dst(gainBus)
  );

  assign mixBus.valid = state.mixValid;
  assign mixBus.i = state.mixI;
  assign mixBus.q = state.mixQ;
  assign outValid = gainBus.valid;
  assign outI = gainBus.i;
  assign outQ = gainBus.q;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    // apb: read data and error are prepared in setup, shown in access
    if (psel && !penable) begin
      next_state.slvErr = ~isMapped(paddr);
      case (paddr)
        `CTRL_OFFSET: next_state.rdata = ctrlWord(state);
        `STATUS_OFFSET: next_state.rdata = {29'h0000_0000, state.mixPhase, thirdBypass};
        `COUNT_OFFSET: next_state.rdata = state.count;
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
    // ratio in the low control bits
    if (psel && penable && pwrite && paddr == `CTRL_OFFSET) begin
      next_state.ratio = ratio_type'(pwdata[`RATIO_LSB +: 2]);
      next_state.c2r = pwdata[`C2R_BIT];
      next_state.gain = pwdata[`GAIN_BIT];
    end
    // sample counter; read-only, wraps after 2^32 samples
    if (gainBus.valid) begin
      next_state.count = state.count + 32'h0000_0001;
    end
    // at a quarter of the rate the rotation terms are only 0 and +/-1,
    // so the mixer is a selection with a sign and needs no multiplier
    // quarter-rate mixer after the final filter
    next_state.mixValid = finalBus.valid;
    if (finalBus.valid) begin
      if (state.c2r) begin
        // rotate by a quarter turn per sample
        case (state.mixPhase)
          2'h0: next_state.mixI = finalBus.i;
          2'h1: next_state.mixI = negate(finalBus.q);
          2'h2: next_state.mixI = negate(finalBus.i);
          default: next_state.mixI = finalBus.q;
        endcase
        next_state.mixQ = {W{1'b0}};
        next_state.mixPhase = state.mixPhase + 2'h1;
      end else begin
        next_state.mixI = finalBus.i;
        next_state.mixQ = finalBus.q;
        next_state.mixPhase = 2'h0;
      end
    end else if (!state.c2r) begin
      // restart the rotation at zero when the mode returns
      next_state.mixPhase = 2'h0;
    end
  end

  // register the state; reset ratio value comes from the reset word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.ratio <= ratio_type'(2'(`CTRL_RESET));
    end else begin
      state <= next_state;
    end
  end

  // zero wait states; the answer is whatever was loaded in setup
  assign pready = 1'b1;
  assign prdata = state.rdata;
  assign pslverr = state.slvErr & psel & penable;

  // ****************************************
  // checks
  // ****************************************
  // the checks watch the registered state, so a mode write shows in them one
  // edge after its access phase; checks that span a mode change look back
  // with $past so that a switch between samples does not trip them
  sequence directReal;
    state.c2r && thirdBypass;
  endsequence

  sequence sampleIntoDirect;
    inValid && state.c2r && thirdBypass;
  endsequence

  chk_q_dropped: assert property (@(posedge clock) disable iff (!rstn)
    $past(state.c2r) && state.mixValid |-> state.mixQ == {W{1'b0}})
    else $error("quadrature sample not dropped");

  chk_full_rate: assert property (@(posedge clock) disable iff (!rstn)
    sampleIntoDirect ##4 directReal |-> outValid)
    else $error("real conversion lost a sample");

  chk_final_halves: assert property (@(posedge clock) disable iff (!rstn)
    !state.c2r && $past(!state.c2r) && finalBus.valid |=> !finalBus.valid)
    else $error("final filter did not decimate");

  chk_mix_negate: assert property (@(posedge clock) disable iff (!rstn)
    state.c2r && finalBus.valid && state.mixPhase == 2'h2 |=>
      state.mixValid && state.mixI == negate($past(finalBus.i)))
    else $error("mixer half-turn sample wrong");

  chk_phase_step: assert property (@(posedge clock) disable iff (!rstn)
    state.c2r && finalBus.valid |=> state.mixPhase == 2'($past(state.mixPhase) + 2'h1))
    else $error("mixer phase did not advance");

  chk_third_skip: assert property (@(posedge clock) disable iff (!rstn)
    thirdBypass && inValid |=> thirdBus.valid && thirdBus.i == $past(inI))
    else $error("bypassed third filter altered data");

  chk_third_halves: assert property (@(posedge clock) disable iff (!rstn)
    !thirdBypass && $past(!thirdBypass) && thirdBus.valid |=> !thirdBus.valid)
    else $error("third filter did not decimate");

  chk_ratio_write: assert property (@(posedge clock) disable iff (!rstn)
    psel && penable && pwrite && paddr == `CTRL_OFFSET |=>
      state.ratio == $past(pwdata[1:0]) && state.c2r == $past(pwdata[`C2R_BIT]))
    else $error("control write not taken");

  chk_unmapped_err: assert property (@(posedge clock) disable iff (!rstn)
    psel && !penable && !isMapped(paddr) ##1 psel && penable |-> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");

  chk_count_step: assert property (@(posedge clock) disable iff (!rstn)
    outValid |=> state.count == $past(state.count) + 32'h1)
    else $error("sample counter missed an output");
endmodule : ddc_back_end

//--- hw/ddc_defs.svh
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
// ****************************************
// register map, byte addresses on the bus
// ****************************************
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define COUNT_OFFSET 12'h008
// ****************************************
// control field positions and reset value
// ****************************************
`define RATIO_LSB 0
`define C2R_BIT 3
`define GAIN_BIT 6
`define CTRL_RESET 8'h00
// ****************************************
// filter geometry and scaling
// ****************************************
`define FINAL_TAPS 55
`define FINAL_CENTRE 524288
`define FINAL_SHIFT 20
`define THIRD_TAPS 19
`define THIRD_CENTRE 131072
`define THIRD_SHIFT 18
`endif

//--- hw/ddc_pkg.sv
package ddc_pkg;
  // ****************************************
  // decimation ratio field of the control word
  // ****************************************
  typedef enum logic [1:0] {
    RATIO_BY4,
    RATIO_BY8,
    RATIO_BY16,
    RATIO_FINAL_ONLY
  } ratio_type;
  // nonzero outer taps, outermost first; the zero taps are never stored
  typedef int final_coef_type [14];
  typedef int third_coef_type [5];
  localparam final_coef_type FINAL_COEF = '{-24, 102, -302, 730, -1544, 2964, -5284,
    8903, -14383, 22640, -35476, 57468, -105442, 331792};
  localparam third_coef_type THIRD_COEF = '{161, -1328, 5814, -19272, 80160};
endpackage : ddc_pkg

//--- hw/sample_if.sv
`timescale 1ns/1ps
// complex sample stream between the channel's own stages
interface sample_if #(parameter int W = 16) ();
  logic valid;
  logic [W-1:0] i;
  logic [W-1:0] q;
  modport src (output valid, output i, output q);
  modport snk (input valid, input i, input q);
endinterface : sample_if

//--- hw/halfband_fir.sv
`timescale 1ns/1ps
`include "ddc_defs.svh"
module halfband_fir import ddc_pkg::*; #(
  parameter int W = 16,
  parameter int TAPS = 55,
  parameter int NSIDE = 14,
  parameter int CENTRE = 524288,
  parameter int SHIFT = 20,
  parameter int COEF [NSIDE] = '{default: 0}
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // mode
  input wire logic decimate,
  input wire logic bypass,
  // streams
  sample_if.snk src,
  sample_if.src dst
);
  localparam int ACC = W + 26;
  localparam int MID = (TAPS - 1) / 2;
  localparam logic signed [ACC-1:0] MAXV = {{(ACC-W+1){1'b0}}, {(W-1){1'b1}}};
  localparam logic signed [ACC-1:0] MINV = ~MAXV;
  // the tap loop assumes zero taps at every odd outer position
  if (TAPS != 4 * NSIDE - 1 || W < 8 || W > 32) begin : g_bad_geometry
    $error("halfband_fir: tap count or width not supported");
  end
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [TAPS-1:0][W-1:0] lineI; // index 0 is the newest sample
    logic [TAPS-1:0][W-1:0] lineQ;
    logic phase;                   // decimation phase
    logic valid;
    logic [W-1:0] outI;
    logic [W-1:0] outQ;
  } fir_state_type;
  fir_state_type state;
  fir_state_type next_state;
  // mirrored taps share one multiply; rounding before the scale-down
  function automatic logic [W-1:0] filterTap(input logic [TAPS-1:0][W-1:0] line);
    logic signed [ACC-1:0] acc;
    acc = ACC'(signed'(line[MID])) * ACC'(CENTRE);
    for (int k = 0; k < NSIDE; k++) begin
      acc = acc + (ACC'(signed'(line[2*k])) + ACC'(signed'(line[TAPS-1-2*k]))) * ACC'(COEF[k]);
    end
    acc = (acc + (ACC'(1) <<< (SHIFT - 1))) >>> SHIFT;
    if (acc > MAXV) begin
      acc = MAXV;
    end else if (acc < MINV) begin
      acc = MINV;
    end
    return acc[W-1:0];
  endfunction : filterTap
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.valid = 1'b0;
    if (src.valid) begin
      if (bypass) begin
        // a bypassed stage forwards every sample, one cycle late
        next_state.valid = 1'b1;
        next_state.outI = src.i;
        next_state.outQ = src.q;
        next_state.phase = 1'b0;
      end else begin
        next_state.lineI = {state.lineI[TAPS-2:0], src.i};
        next_state.lineQ = {state.lineQ[TAPS-2:0], src.q};
        next_state.outI = filterTap(next_state.lineI);
        next_state.outQ = filterTap(next_state.lineQ);
        // one output per input when not decimating
        next_state.valid = decimate ? state.phase : 1'b1;
        next_state.phase = decimate ? ~state.phase : 1'b0;
      end
    end
  end
  // register the state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign dst.valid = state.valid;
  assign dst.i = state.outI;
  assign dst.q = state.outQ;
  chk_decim_alternate: assert property (@(posedge clock) disable iff (!rstn)
    src.valid && !bypass && decimate && !state.phase |=> !dst.valid && state.phase)
    else $error("decimating stage emitted on an even input");
endmodule : halfband_fir

//--- hw/gain_stage.sv
`timescale 1ns/1ps
module gain_stage import ddc_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // mode
  input wire logic gain6db,
  // streams
  sample_if.snk src,
  sample_if.src dst
);
  localparam logic signed [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};
  // a one-bit word has no room for a clipped double
  if (W < 2) begin : g_bad_width
    $error("gain_stage: sample width not supported");
  end
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [W-1:0] i;
    logic [W-1:0] q;
  } gain_state_type;
  gain_state_type state;
  gain_state_type next_state;
  // saturating left shift
  // doubling by shift; clip instead of wrapping at full scale
  function automatic logic [W-1:0] scale(input logic [W-1:0] x, input logic dbl);
    logic signed [W:0] wide;
    wide = {x[W-1], x} <<< dbl;
    if (wide > (W+1)'(MAXV)) begin
      return MAXV;
    end else if (wide < (W+1)'(MINV)) begin
      return MINV;
    end
    return wide[W-1:0];
  endfunction : scale
  always_comb begin
    next_state.valid = src.valid;
    next_state.i = src.valid ? scale(src.i, gain6db) : state.i;
    next_state.q = src.valid ? scale(src.q, gain6db) : state.q;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign dst.valid = state.valid;
  assign dst.i = state.i;
  assign dst.q = state.q;
  chk_gain_clip: assert property (@(posedge clock) disable iff (!rstn)
    src.valid && gain6db && signed'(src.i) > (MAXV >>> 1) |=> dst.i == MAXV)
    else $error("doubled sample did not clip to full scale");
  chk_gain_unity: assert property (@(posedge clock) disable iff (!rstn)
    src.valid && !gain6db |=> dst.valid && dst.i == $past(src.i) && dst.q == $past(src.q))
    else $error("unity gain altered the sample");
endmodule : gain_stage

//--- test/mixer_source.sv
`timescale 1ns/1ps
// ****************************************
// upstream mixer model feeding the back end
// ****************************************
// nothing upstream is bound by a rule here; it sends one sample per valid cycle
module mixer_source #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control from the bench
  input wire logic run,
  input wire logic gap,
  input wire logic [W-1:0] sampI,
  input wire logic [W-1:0] sampQ,
  // stream toward the block
  output logic inValid,
  output logic [W-1:0] inI,
  output logic [W-1:0] inQ
);
  // set after a sample when slow pacing is asked for
  logic idle;
  // registered source; between samples the data lines flip so stale values never look valid
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      inValid <= 1'b0;
      inI <= '0;
      inQ <= '0;
      idle <= 1'b0;
    end else if (run && !idle) begin
      inValid <= 1'b1;
      inI <= sampI;
      inQ <= sampQ;
      idle <= gap;
    end else begin
      inValid <= 1'b0;
      inI <= ~inI;
      inQ <= ~inQ;
      idle <= 1'b0;
    end
  end
endmodule : mixer_source

//--- test/tb_ddc_final_halfband_gain_c2r.sv
`timescale 1ns/1ps
`include "ddc_defs.svh"
module tb_ddc_final_halfband_gain_c2r import ddc_pkg::*;;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("FAIL %0t got %0h exp %0h", $time, g, e); end end
  // one expected output: edge count, whether the value is checked, the value
  typedef struct {int at; bit chk; logic [15:0] i; logic [15:0] q;} exp_type;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, run, gap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic inValid, outValid;
  logic [15:0] inI, inQ, outI, outQ, sampI, sampQ;
  exp_type expQ[$];
  int bad_count, compares, cyc, nIn, notes, ratio, seed;
  bit c2r, gain, imp;
  longint dcI, dcQ, amp;
  ddc_back_end #(.W(16)) u_ddc_back_end (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .inValid(inValid), .inI(inI), .inQ(inQ), .outValid(outValid), .outI(outI), .outQ(outQ));
  mixer_source #(.W(16)) u_mixer_source (.clock(clock), .rstn(rstn), .run(run), .gap(gap), .sampI(sampI),
    .sampQ(sampQ), .inValid(inValid), .inI(inI), .inQ(inQ));
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ****************************************
  // arithmetic of the reference
  // ****************************************
  // round half up, then drop the 20 fraction bits of the final filter
  function automatic longint rnd(longint p);
    return (p + 64'sh80000) >>> 20;
  endfunction : rnd
  // clip to the signed output word
  function automatic logic [15:0] sat(longint v);
    if (v > 32767) return 16'h7FFF;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction : sat
  // final taps by position: centre at 27, even positions hold the outer ones mirrored about it
  function automatic int tap(int t);
    if (t == 27) return `FINAL_CENTRE;
    if (t < 0 || t > 54 || t % 2 != 0) return 0;
    return FINAL_COEF[(t <= 26) ? t / 2 : (54 - t) / 2];
  endfunction : tap
  // closing report, also used by the hang guard
  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ****************************************
  // scoreboard: output check, then notes for new inputs
  // ****************************************
  // cycle count; non-blocking, so the note and the watch see one value per edge
  always @(posedge clock) begin : tick
    cyc <= cyc + 1;
    // hang guard, about two and a half times the planned run
    if (cyc > 8000) begin
      bad_count++;
      end_of_test();
    end
  end
  // watch: takes the oldest note whenever the framer side shows a sample
  always @(posedge clock) begin : watch
    exp_type e;
    if (outValid === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK(1'b1, 1'b0) // no output expected here
      end else begin
        e = expQ.pop_front();
        `CHK(cyc, e.at) // output rate and phase
        if (e.chk) begin
          `CHK(outI, e.i) // in-phase value
          `CHK(outQ, e.q) // quadrature value
        end
      end
    end
  end
  // note: the driving side records what each new input should produce
  always @(posedge clock) begin : note
    int m;
    int p;
    bit keep;
    longint vi;
    longint vq;
    if (inValid === 1'b1) begin
      // third stage keeps odd inputs unless bypassed, final keeps odd ones unless converting to real
      keep = (ratio == 3) || (nIn % 2 == 1);
      m = (ratio == 3) ? nIn : nIn / 2;
      keep = keep && (c2r || m % 2 == 1);
      p = c2r ? m : m / 2;
      vi = imp ? rnd(amp * tap(nIn - 1)) : dcI;
      vq = imp ? rnd(-amp * tap(nIn - 1)) : dcQ;
      // quarter-rate rotation keeps the real part only
      if (c2r) begin
        vi = (p % 4 == 0) ? vi : (p % 4 == 1) ? -vq : (p % 4 == 2) ? -vi : vq;
        vq = 0;
      end
      if (keep) begin
        expQ.push_back('{cyc + 4, imp || nIn >= 150, sat(gain ? 2 * vi : vi), sat(gain ? 2 * vq : vq)});
        notes++;
      end
      nIn++;
    end
  end
  // one configuration from reset: write control, stream 400 cycles, drain, check count
  task automatic scen(input int r, input bit c, input bit g, input bit im, input bit gp);
    logic [31:0] rd;
    logic er;
    rstn <= 1'b0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    ratio = r;
    c2r = c;
    gain = g;
    imp = im;
    nIn = 0;
    notes = 0;
    // in-phase level above half scale, so a doubled sample always clips
    dcI = 17000 + ($random(seed) & 32'h0000_0FFF);
    dcQ = $random(seed) % 20000;
    apb(1'b1, `CTRL_OFFSET, 32'(r) | (32'(c) << `C2R_BIT) | (32'(g) << `GAIN_BIT), rd, er);
    apb(1'b0, `STATUS_OFFSET, 32'h0, rd, er);
    `CHK(rd[0], 1'(r == 3)) // bypass flag
    gap <= gp;
    for (int k = 0; k < 400; k++) begin
      @(posedge clock);
      run <= 1'b1;
      sampI <= im ? ((k == 1) ? amp[15:0] : 16'h0000) : dcI[15:0];
      sampQ <= im ? ((k == 1) ? 16'(-amp) : 16'h0000) : dcQ[15:0];
    end
    @(posedge clock);
    run <= 1'b0;
    repeat (10) @(posedge clock);
    `CHK(expQ.size(), 0) // every output arrived
    apb(1'b0, `COUNT_OFFSET, 32'h0, rd, er);
    `CHK(rd, 32'(notes)) // output count
    apb(1'b0, `STATUS_OFFSET, 32'h0, rd, er);
    `CHK(rd[2:1], c ? 2'(notes % 4) : 2'h0) // mixer phase per output
  endtask : scen
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] rd;
    logic er;
    seed = 95885;
    amp = 30000;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 1'b0;
    gap = 1'b0;
    sampI = 16'h0000;
    sampQ = 16'h0000;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, `CTRL_OFFSET, 32'h0, rd, er);
    `CHK(rd, 32'(`CTRL_RESET)) // control reset value
    apb(1'b0, `COUNT_OFFSET, 32'h0, rd, er);
    `CHK(rd, 32'h0) // count starts at zero
    apb(1'b1, `CTRL_OFFSET, 32'hFFFFFFFF, rd, er);
    apb(1'b0, `CTRL_OFFSET, 32'h0, rd, er);
    `CHK(rd, 32'h0000004B) // only the defined bits stick
    apb(1'b1, 12'h00C, 32'h0, rd, er);
    `CHK(er, 1'b1) // unmapped write refused
    apb(1'b1, `STATUS_OFFSET, 32'h0, rd, er);
    `CHK(er, 1'b0) // status write ignored quietly
    apb(1'b0, `STATUS_OFFSET, 32'h0, rd, er);
    `CHK(rd[0], 1'b1) // final-only ratio bypasses third stage
    // impulse shows every outer tap; final decimation stays on here
    scen(3, 1'b0, 1'b0, 1'b1, 1'b0); // impulse response
    // full-rate impulse reaches the centre tap and every rotation step
    scen(3, 1'b1, 1'b0, 1'b1, 1'b0); // centre tap rotated
    // complex input needs no gain; slow pacing
    scen(0, 1'b0, 1'b0, 1'b0, 1'b1); // third stage in path
    scen(1, 1'b0, 1'b1, 1'b0, 1'b0); // gain on
    // real path with the recommended gain
    scen(2, 1'b1, 1'b1, 1'b0, 1'b0); // real output
    scen(3, 1'b1, 1'b0, 1'b0, 1'b1); // one output per input
    scen(3, 1'b0, 1'b1, 1'b0, 1'b0); // saturation on large levels
    end_of_test();
  end
endmodule : tb_ddc_final_halfband_gain_c2r
